// file: shared/aofor_defines.svh
`ifndef AOFOR_DEFINES_SVH
`define AOFOR_DEFINES_SVH
// Operation
// - polarity bit 0: bipolar, two's-complement output
// - polarity bit 1: unipolar, straight-binary output
// - link CRC on: check input, append output CRC
// - link CRC mismatch sets link error flag
// - writing one clears the link error flag
// - compare expected CRC with registers 0-1,4-E
// - register CRC mismatch sets register error flag
// - status enable prefixes status byte to data
// - offset word from bytes 9h,Ah,Bh high-to-low
// - subtract signed offset from every result
// - offset subtraction precedes gain correction
// - offset bytes reset to zero
// - multiply by gain over 400000h, unity gain
// - CRC register is scratch when checking off

// ============================================================
// register indices (byte address = 4 * index)
`define AOFOR_IDX_CTRL      4'h8
`define AOFOR_IDX_OFS_HI    4'h9
`define AOFOR_IDX_OFS_MID   4'hA
`define AOFOR_IDX_OFS_LO    4'hB
`define AOFOR_IDX_GAIN_HI   4'hC
`define AOFOR_IDX_GAIN_MID  4'hD
`define AOFOR_IDX_GAIN_LO   4'hE
`define AOFOR_IDX_REG_CRC   4'hF
`define AOFOR_IDX_STATUS    4'h2

// ============================================================
// reset values
`define AOFOR_RST_CTRL      8'h08
`define AOFOR_RST_OFS       8'h00
`define AOFOR_RST_GAIN_HI   8'h40
`define AOFOR_RST_GAIN_LO   8'h00
`define AOFOR_RST_CRC       8'h00

// ============================================================
// control and status fields
`define AOFOR_CTRL_RW_MASK  8'hF7
`define AOFOR_BIT_POLARITY  4
`define AOFOR_BIT_LINK_CRC  2
`define AOFOR_BIT_REG_CRC   1
`define AOFOR_BIT_STATUS    0
`define AOFOR_STS_LINK_ERR  1
`define AOFOR_STS_REG_ERR   0

// ============================================================
// arithmetic constants
`define AOFOR_CRC_POLY      8'h07
`define AOFOR_GAIN_SHIFT    22
`define AOFOR_POS_MAX       24'h7FFFFF
`define AOFOR_NEG_MIN       24'h800000
`endif

// file: shared/aofor_pkg.sv
package aofor_pkg;
    // conversion result arriving from the filter
    typedef struct packed {
        logic        valid;
        logic [23:0] data;
    } aofor_conv_t;

    // one received frame's CRC check from the serial link
    typedef struct packed {
        logic       valid;
        logic [7:0] calc;
        logic [7:0] recv;
    } aofor_link_rx_t;

    // formatted output word for the serial shifter
    typedef struct packed {
        logic        valid;
        logic        status_on;
        logic [7:0]  status;
        logic [23:0] data;
        logic        crc_on;
        logic [7:0]  crc;
    } aofor_out_t;
endpackage

// file: hdl/aofor_top.sv
`include "aofor_defines.svh"

module aofor_top (
    // clock and reset
    input  wire logic                clk,
    input  wire logic                rstn,
    // avalon-mm slave
    input  wire logic [5:0]          address,
    input  wire logic                read,
    input  wire logic                write,
    input  wire logic [31:0]         writedata,
    output logic      [31:0]         readdata,
    output logic                     waitrequest,
    // registers 0h,1h,4h..7h held elsewhere in the device, in that order
    input  wire logic [47:0]         ext_reg_bytes,
    // serial link check results
    input  wire aofor_pkg::aofor_link_rx_t link_rx,
    // conversion path
    input  wire aofor_pkg::aofor_conv_t    conv_in,
    output aofor_pkg::aofor_out_t          conv_out,
    // control levels for the serial shifter
    output logic                     link_crc_en
);
    import aofor_pkg::*;

    // ============================================================
    // crc-8 helper, msb first, zero seed
    function automatic logic [7:0] crc8_byte(input logic [7:0] crc, input logic [7:0] d);
        logic [7:0] c;
        c = crc ^ d;
        for (int i = 0; i < 8; i++)
        begin
            c = c[7] ? ((c << 1) ^ `AOFOR_CRC_POLY) : (c << 1);
        end
        return c;
    endfunction

    // ============================================================
    // register storage
    logic [7:0]  ctrl_r;
    logic [7:0]  ofs_r  [3];
    logic [7:0]  gain_r [3];
    logic [7:0]  crc_exp_r;
    logic        link_err_r;
    logic        reg_err_r;
    logic [7:0]  reg_crc_r;
    logic        waitrequest_r;
    logic [31:0] readdata_r;
    logic        link_crc_en_r;

    // ============================================================
    // bus decode
    wire         req       = read | write;
    wire         accept    = req & ~waitrequest_r;
    wire         wr_acc    = accept & write;
    wire [4:0]   idx       = {1'b0, address[5:2]};
    wire [7:0]   wbyte     = writedata[7:0];
    wire         sel_ctrl  = (idx == {1'b0, `AOFOR_IDX_CTRL});
    wire         sel_crc   = (idx == {1'b0, `AOFOR_IDX_REG_CRC});
    wire         sel_stat  = (idx == {1'b0, `AOFOR_IDX_STATUS});
    wire         in_ofs    = (idx >= {1'b0, `AOFOR_IDX_OFS_HI}) &&
                             (idx <= {1'b0, `AOFOR_IDX_OFS_LO});
    wire         in_gain   = (idx >= {1'b0, `AOFOR_IDX_GAIN_HI}) &&
                             (idx <= {1'b0, `AOFOR_IDX_GAIN_LO});
    wire [1:0]   ofs_sel   = 2'(idx - {1'b0, `AOFOR_IDX_OFS_HI});
    wire [1:0]   gain_sel  = 2'(idx - {1'b0, `AOFOR_IDX_GAIN_HI});

    // status sits outside the map crc range; only its link bit is writable (one clears)

    wire [7:0]   status_byte = {6'h00, link_err_r, reg_err_r};

    // ============================================================
    // read mux, prepared one cycle ahead of the accepting edge
    logic [7:0] rd_byte;
    always_comb
    begin
        rd_byte = 8'h00;
        if (sel_ctrl)
            rd_byte = ctrl_r | `AOFOR_RST_CTRL & ~`AOFOR_CTRL_RW_MASK;
        else if (in_ofs)
            rd_byte = ofs_r[ofs_sel];
        else if (in_gain)
            rd_byte = gain_r[gain_sel];
        else if (sel_crc)
            rd_byte = crc_exp_r;
        else if (sel_stat)
            rd_byte = status_byte;
    end

    // only the low byte carries data; upper lanes read as zero
    wire [31:0] readdata_nxt = {24'h000000, rd_byte};

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            waitrequest_r <= 1'b1;
            readdata_r    <= 32'h00000000;
        end
        else
        begin
            waitrequest_r <= ~(req & waitrequest_r);
            if (req & waitrequest_r)
                readdata_r <= readdata_nxt;
        end
    end

    // ============================================================
    // register writes
    wire [7:0] ctrl_nxt = (wbyte & `AOFOR_CTRL_RW_MASK) | (`AOFOR_RST_CTRL & ~`AOFOR_CTRL_RW_MASK);

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            ctrl_r    <= `AOFOR_RST_CTRL;
            crc_exp_r <= `AOFOR_RST_CRC;
        end
        else if (wr_acc)
        begin
            if (sel_ctrl)
                ctrl_r <= ctrl_nxt;
            if (sel_crc)
                crc_exp_r <= wbyte;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : g_bytes
            always_ff @(posedge clk)
            begin
                if (!rstn)
                begin
                    ofs_r[g]  <= `AOFOR_RST_OFS;
                    gain_r[g] <= (g == 0) ? `AOFOR_RST_GAIN_HI : `AOFOR_RST_GAIN_LO;
                end
                else if (wr_acc)
                begin
                    if (in_ofs && ofs_sel == 2'(g))
                        ofs_r[g] <= wbyte;
                    if (in_gain && gain_sel == 2'(g))
                        gain_r[g] <= wbyte;
                end
            end
        end
    endgenerate

    // ============================================================
    // control fields
    wire pol_uni   = ctrl_r[`AOFOR_BIT_POLARITY];
    wire link_on   = ctrl_r[`AOFOR_BIT_LINK_CRC];
    wire regcrc_on = ctrl_r[`AOFOR_BIT_REG_CRC];
    wire status_on = ctrl_r[`AOFOR_BIT_STATUS];

    // ============================================================
    // link crc error flag: set wins over the write-one clear
    wire link_mis  = link_on & link_rx.valid & (link_rx.calc != link_rx.recv);
    wire link_clr  = wr_acc & sel_stat & wbyte[`AOFOR_STS_LINK_ERR];

    // ============================================================
    // register-map crc over 0h-1h, 4h-Eh
    logic [7:0] map_crc;
    always_comb
    begin
        map_crc = 8'h00;
        for (int i = 0; i < 6; i++)
            map_crc = crc8_byte(map_crc, ext_reg_bytes[47 - 8*i -: 8]);
        map_crc = crc8_byte(map_crc, ctrl_r);
        for (int i = 0; i < 3; i++)
            map_crc = crc8_byte(map_crc, ofs_r[i]);
        for (int i = 0; i < 3; i++)
            map_crc = crc8_byte(map_crc, gain_r[i]);
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            reg_crc_r     <= 8'h00;
            link_crc_en_r <= 1'b0;
        end
        else
        begin
            reg_crc_r     <= map_crc;
            link_crc_en_r <= link_on;
        end
    end

    // ============================================================
    // link error is sticky; a mismatch in the clear's cycle wins so no error is lost
    always_ff @(posedge clk)
    begin
        if (!rstn)
            link_err_r <= 1'b0;
        else if (link_mis)
            link_err_r <= 1'b1;
        else if (link_clr)
            link_err_r <= 1'b0;
    end

    // register error is a level that follows the compare while enabled
    always_ff @(posedge clk)
    begin
        if (!rstn)
            reg_err_r <= 1'b0;
        else
            reg_err_r <= regcrc_on & (reg_crc_r != crc_exp_r);
    end

    // ============================================================
    // stage 1: offset subtraction with clamp
    wire signed [23:0] ofs_word = {ofs_r[0], ofs_r[1], ofs_r[2]};
    wire signed [24:0] diff     = {conv_in.data[23], conv_in.data} -
                                  {ofs_word[23], ofs_word};
    wire [23:0] diff_sat = (diff[24] == diff[23]) ? diff[23:0] :
                           (diff[24] ? `AOFOR_NEG_MIN : `AOFOR_POS_MAX);

    logic        s1_valid_r;
    logic [23:0] s1_data_r;

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            s1_valid_r <= 1'b0;
            s1_data_r  <= 24'h000000;
        end
        else
        begin
            s1_valid_r <= conv_in.valid;
            if (conv_in.valid)
                s1_data_r <= diff_sat;
        end
    end

    // ============================================================
    // stage 2: gain, 400000h is unity
    wire [23:0]        gain_word = {gain_r[0], gain_r[1], gain_r[2]};
    wire signed [48:0] prod      = $signed(s1_data_r) * $signed({1'b0, gain_word});
    wire signed [26:0] scaled    = 27'(prod >>> `AOFOR_GAIN_SHIFT);
    wire               g_ovf     = (scaled[26:23] != {4{scaled[23]}});
    wire [23:0] gain_sat = !g_ovf ? scaled[23:0] :
                           (scaled[26] ? `AOFOR_NEG_MIN : `AOFOR_POS_MAX);

    logic        s2_valid_r;
    logic [23:0] s2_data_r;

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            s2_valid_r <= 1'b0;
            s2_data_r  <= 24'h000000;
        end
        else
        begin
            s2_valid_r <= s1_valid_r;
            if (s1_valid_r)
                s2_data_r <= gain_sat;
        end
    end

    // ============================================================
    // stage 3: coding and framing
    // unipolar drops the sign: negative readings pin at zero code
    wire [23:0] coded = pol_uni ? (s2_data_r[23] ? 24'h000000 : {s2_data_r[22:0], 1'b0})
                                : s2_data_r;
    wire [7:0]  sts_now = status_byte;

    logic [7:0] out_crc;
    always_comb
    begin
        out_crc = 8'h00;
        if (status_on)
            out_crc = crc8_byte(out_crc, sts_now);
        out_crc = crc8_byte(out_crc, coded[23:16]);
        out_crc = crc8_byte(out_crc, coded[15:8]);
        out_crc = crc8_byte(out_crc, coded[7:0]);
    end

    aofor_out_t out_r;

    always_ff @(posedge clk)
    begin
        if (!rstn)
            out_r <= '0;
        else
        begin
            out_r.valid <= s2_valid_r;
            if (s2_valid_r)
            begin
                out_r.status_on <= status_on;
                out_r.status    <= status_on ? sts_now : 8'h00;
                out_r.data      <= coded;
                out_r.crc_on    <= link_on;
                out_r.crc       <= link_on ? out_crc : 8'h00;
            end
        end
    end

    assign readdata    = readdata_r;
    assign waitrequest = waitrequest_r;
    assign conv_out    = out_r;
    assign link_crc_en = link_crc_en_r;
endmodule

// file: verif/aofor_top_properties.sv
`include "aofor_defines.svh"

// ============================================================
// port checks
module aofor_top_properties (
    // clock and reset
    input wire logic                      clk,
    input wire logic                      rstn,
    // register bus
    input wire logic [5:0]                address,
    input wire logic                      read,
    input wire logic                      write,
    input wire logic [31:0]               writedata,
    input wire logic [31:0]               readdata,
    input wire logic                      waitrequest,
    // data path
    input wire logic [47:0]               ext_reg_bytes,
    input wire aofor_pkg::aofor_link_rx_t link_rx,
    input wire aofor_pkg::aofor_conv_t    conv_in,
    input wire aofor_pkg::aofor_out_t     conv_out,
    input wire logic                      link_crc_en
);
    import aofor_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    AST_RESET_OUT: assert property (!$past(rstn) |->
        waitrequest && conv_out == '0 && !link_crc_en) else $error("reset outputs");
    AST_BUS_ANSWER: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("no answer");
    AST_BUS_SINGLE: assert property (!waitrequest |=> waitrequest)
        else $error("answer too long");
    // reset edge may clear it, so only compare across two running cycles
    AST_RDATA_HOLD: assert property (waitrequest && $past(waitrequest) && $past(rstn)
        |-> $stable(readdata)) else $error("read data moved");
    AST_CONV_LATENCY: assert property (conv_in.valid |-> ##3 conv_out.valid)
        else $error("result late");
    AST_CONV_NO_EXTRA: assert property (conv_out.valid |-> $past(conv_in.valid, 3))
        else $error("extra result");
    AST_LINK_EN: assert property (write && !waitrequest
        && address[5:2] == `AOFOR_IDX_CTRL |-> ##2 link_crc_en == $past(writedata[2], 2))
        else $error("link enable");
    AST_CRC_FLAG: assert property (conv_out.valid |-> conv_out.crc_on == link_crc_en)
        else $error("crc flag");

    cover property (conv_out.valid && conv_out.status[1]);
    cover property (conv_out.valid && conv_out.status[0]);
    cover property (conv_out.valid && conv_out.crc_on);
endmodule

bind aofor_top aofor_top_properties i_props (.clk, .rstn, .address, .read, .write, .writedata,
    .readdata, .waitrequest, .ext_reg_bytes, .link_rx, .conv_in, .conv_out, .link_crc_en);

// file: verif/aofor_link_host.sv
// ============================================================
// crc-8, poly 07h, seed 00h, msb first over the low n bits
package aofor_tb_pkg;
    function automatic logic [7:0] crc8(input logic [111:0] v, input int n);
        logic [7:0] c;
        c = 8'h00;
        for (int i = n - 1; i >= 0; i--)
            c = {c[6:0], 1'b0} ^ ((c[7] ^ v[i]) ? 8'h07 : 8'h00);
        return c;
    endfunction
endpackage

// ============================================================
// far-side serial host: raises frame checks, audits output crc
module aofor_link_host (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rstn,
    // frame commands
    input  wire logic                  send,
    input  wire logic                  corrupt,
    // device side
    input  wire aofor_pkg::aofor_out_t conv_out,
    output aofor_pkg::aofor_link_rx_t  link_rx,
    output int                         crc_bad
);
    timeunit 1ns;
    timeprecision 1ps;
    import aofor_pkg::*;
    import aofor_tb_pkg::*;
    logic [7:0] seq_r;
    logic [7:0] crc_exp;

    assign crc_exp = conv_out.status_on ? crc8({conv_out.status, conv_out.data}, 32)
                                        : crc8(conv_out.data, 24);

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            seq_r <= 8'h00;
            link_rx <= '0;
            crc_bad <= 0;
        end
        else
        begin
            // bytes keep changing between frames so stale values never pass
            seq_r <= seq_r + 8'h3B;
            link_rx.valid <= send;
            link_rx.calc <= seq_r;
            link_rx.recv <= corrupt ? ~seq_r : seq_r;
            if (conv_out.valid && conv_out.crc_on && conv_out.crc !== crc_exp)
                crc_bad <= crc_bad + 1;
        end
    end
endmodule

// file: verif/testbench.sv
`include "aofor_defines.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("unexpected t=%0t got %h exp %h", $time, g, e); end end

// ============================================================
// top-level bench
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import aofor_pkg::*;
    import aofor_tb_pkg::*;
    logic clk = 0, rstn = 0, read = 0, write = 0, send = 0, corrupt = 0;
    logic waitrequest, link_crc_en;
    logic [5:0] address = '0;
    logic [31:0] writedata = '0, readdata, rd;
    logic [47:0] ext = '0;
    logic [23:0] ofs = '0, gain = 24'h400000;
    aofor_conv_t conv_in = '0;
    aofor_out_t conv_out;
    aofor_link_rx_t link_rx;
    int mismatches = 0, total_checks = 0, crc_bad;
    logic [11:0] rst_tab[9] = '{12'h808, 12'h900, 12'hA00, 12'hB00, 12'hC40, 12'hD00,
        12'hE00, 12'hF00, 12'h100};

    always #5 clk = ~clk;

    aofor_top i_dut (.clk, .rstn, .address, .read, .write, .writedata, .readdata,
        .waitrequest, .ext_reg_bytes(ext), .link_rx, .conv_in, .conv_out, .link_crc_en);
    aofor_link_host i_host (.clk, .rstn, .send, .corrupt, .conv_out, .link_rx, .crc_bad);

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic bus(input logic wr, input logic [3:0] idx, input logic [7:0] d);
        int n;
        @(posedge clk);
        read <= !wr;
        write <= wr;
        address <= {idx, 2'b00};
        writedata <= {24'h000000, d};
        for (n = 0; n < 20; n++)
        begin
            @(posedge clk);
            if (waitrequest === 1'b0)
                break;
        end
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (n == 20)
        begin
            mismatches++;
            report_and_stop();
        end
    endtask

    task automatic set24(input logic [3:0] idx, input logic [23:0] v);
        bus(1'b1, idx, v[23:16]);
        bus(1'b1, idx + 4'h1, v[15:8]);
        bus(1'b1, idx + 4'h2, v[7:0]);
    endtask

    function automatic longint sat(input longint v);
        return v > 64'sd8388607 ? 64'sd8388607 : (v < -64'sd8388608 ? -64'sd8388608 : v);
    endfunction

    // offset first, then gain, then the unipolar remap
    function automatic logic [23:0] model_out(input logic [23:0] x, input logic uni);
        longint v;
        v = sat(longint'($signed(x)) - longint'($signed(ofs)));
        v = sat((v * longint'(gain)) >>> 22);
        if (uni)
            v = v < 0 ? 0 : v * 2;
        return v[23:0];
    endfunction

    task automatic conv(input logic [23:0] x, input logic uni);
        @(posedge clk);
        conv_in <= '{1'b1, x};
        @(posedge clk);
        conv_in.valid <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK(conv_out.valid, 1'b1)
        `CHK(conv_out.data, model_out(x, uni))
    endtask

    initial
    begin
        void'($urandom(18));
        ext <= 48'({$urandom, $urandom});
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        foreach (rst_tab[i])
        begin
            bus(1'b0, rst_tab[i][11:8], 8'h00);
            `CHK(rd, {24'h000000, rst_tab[i][7:0]})
        end
        bus(1'b1, `AOFOR_IDX_REG_CRC, 8'hA5);
        bus(1'b0, `AOFOR_IDX_REG_CRC, 8'h00);
        `CHK(rd[7:0], 8'hA5)
        conv(24'h123456, 1'b0);
        `CHK(conv_out.status_on, 1'b0)
        for (int k = 0; k < 8; k++)
        begin
            ofs = k == 0 ? 24'h800000 : (k == 1 ? 24'h7FFFFF : 24'($urandom));
            gain = k < 4 ? 24'h400000 : 24'($urandom_range(32'h007FFFFF));
            set24(`AOFOR_IDX_OFS_HI, ofs);
            set24(`AOFOR_IDX_GAIN_HI, gain);
            bus(1'b0, `AOFOR_IDX_OFS_MID, 8'h00);
            `CHK(rd[7:0], ofs[15:8])
            conv(24'h7FFFFF, 1'b0);
            conv(24'h800000, 1'b0);
            conv(24'($urandom), 1'b0);
        end
        gain = 24'h400000;
        set24(`AOFOR_IDX_GAIN_HI, gain);
        bus(1'b1, `AOFOR_IDX_CTRL, 8'h10);
        conv(24'h800000, 1'b1);
        repeat (4) conv(24'($urandom), 1'b1);
        bus(1'b1, `AOFOR_IDX_CTRL, 8'h05);
        for (int c = 0; c < 2; c++)
        begin
            @(posedge clk);
            send <= 1'b1;
            corrupt <= c[0];
            @(posedge clk);
            send <= 1'b0;
            conv(24'($urandom), 1'b0);
            `CHK(conv_out.status[1], c[0])
        end
        `CHK(conv_out.status_on, 1'b1)
        `CHK(crc_bad, 0)
        bus(1'b0, `AOFOR_IDX_STATUS, 8'h00);
        `CHK(rd[7:0], 8'h02)
        // a one on the register-error bit alone must not clear the link flag
        bus(1'b1, `AOFOR_IDX_STATUS, 8'h01);
        bus(1'b0, `AOFOR_IDX_STATUS, 8'h00);
        `CHK(rd[7:0], 8'h02)
        bus(1'b1, `AOFOR_IDX_STATUS, 8'h02);
        bus(1'b0, `AOFOR_IDX_STATUS, 8'h00);
        `CHK(rd[7:0], 8'h00)
        bus(1'b1, `AOFOR_IDX_CTRL, 8'h07);
        for (int c = 0; c < 2; c++)
        begin
            // control reads back with its fixed bit 3 set
            bus(1'b1, `AOFOR_IDX_REG_CRC, crc8({ext, 8'h0F, ofs, gain}, 104) ^ c[7:0]);
            conv(24'($urandom), 1'b0);
            `CHK(conv_out.status[0], c[0])
        end
        report_and_stop();
    end
endmodule
